// File: shared/ftp_cfg.svh
// Timing, field position and supervision channel constants of the furnace timing block.
`ifndef FTP_CFG_SVH
`define FTP_CFG_SVH

// ****************************************************************
// Clock and one-second tick
// ****************************************************************
`define FTP_CLK_PERIOD_NS 32'h0000_0032
`define FTP_TICK_MS       32'h0000_03E8
`define FTP_TICK_CYC ((`FTP_TICK_MS * 32'h000F_4240) / `FTP_CLK_PERIOD_NS)

// ****************************************************************
// Fixed parameters: delays in seconds (one tick each), retry, recycle and lock counts
// ****************************************************************
`define FTP_PREPURGE_S    12'h01E
`define FTP_INTERPURGE_S  12'h03C
`define FTP_POSTPURGE_S   12'h00F
`define FTP_COOL_ON_S     12'h005
`define FTP_RESTART_S     12'hE10
`define FTP_FLAME_FAIL_S  12'h002
`define FTP_DEBOUNCE_S    12'h002
`define FTP_SHORT_CYC_S   12'h12C
`define FTP_FALSE_FLAME_S 12'h014
`define FTP_RETRIES       2'h2
`define FTP_RECYCLES      2'h3
`define FTP_LOCK_CYCLES   4'hA
`define FTP_HEAT_GATE_S   5'h14
`define FTP_COOL_GATE_S   5'h0A

// ****************************************************************
// Switch decodes and fixed recognition time, in seconds
// ****************************************************************
`define FTP_COOL_OFF_OFF  12'h000
`define FTP_COOL_OFF_ON   12'h03C
`define FTP_HEAT_ON_OFF   12'h01E
`define FTP_HEAT_ON_ON    12'h03C
`define FTP_HOFF_00       12'h078
`define FTP_HOFF_01       12'h0B4
`define FTP_HOFF_10       12'h05A
`define FTP_HOFF_11       12'h03C
`define FTP_WARM_FIRST    12'h011
`define FTP_WARM_NEXT     12'h01B
`define FTP_WARM_LONG     12'h01E
`define FTP_RECOG_S       12'h003

// ****************************************************************
// Field bit positions and supervision channel indices
// ****************************************************************
`define FTP_FS_COOL_OFF   0
`define FTP_FS_HEAT_ON    1
`define FTP_FS_HOFF_A     2
`define FTP_FS_HOFF_B     3
`define FTP_SV_FLAME_FAIL 0
`define FTP_SV_FAULT      1
`define FTP_SV_FALSE      2

`endif

// File: shared/ftp_pkg.sv
// Types shared by the furnace timing block.
package ftp_pkg;

    typedef logic [11:0] ftp_sec_t;

    // Fan delays, used for own settings and the partner's.
    typedef struct packed {
        ftp_sec_t cool_on;
        ftp_sec_t cool_off;
        ftp_sec_t heat_on;
        ftp_sec_t heat_off;
    } ftp_fan_t;

    // Everything the ignition and fan sequencer consumes.
    typedef struct packed {
        ftp_sec_t  prepurge;
        ftp_sec_t  interpurge;
        ftp_sec_t  postpurge;
        ftp_sec_t  restart;
        logic [1:0] retries;
        logic [1:0] recycles;
        ftp_sec_t  warmup;
        ftp_sec_t  trial;
        ftp_sec_t  activation;
        ftp_sec_t  recognition;
        ftp_sec_t  short_cycle;
        ftp_fan_t  fan;
    } ftp_timing_t;

endpackage

// File: verilog/ftp_tick.sv
// One-second tick divider for the furnace timing block.
`timescale 1ns/1ns
module ftp_tick #(
    parameter int unsigned CYC = 20000000
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic nrst,
    // Tick pulse
    output logic      tick_q
);
    localparam int unsigned W = $clog2(CYC);

    if (CYC < 2) begin : g_chk
        $error("ftp_tick: CYC must be at least 2");
    end

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         tick_d;

    // Count down one second worth of cycles, pulse at wrap.
    always_comb begin
        tick_d = (cnt_q == '0);
        cnt_d  = tick_d ? W'(CYC - 1) : cnt_q - 1'b1;
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end
endmodule

// File: verilog/ftp_timer.sv
// Tick-based delay timer that latches its length at start.
`timescale 1ns/1ns
module ftp_timer #(
    parameter int unsigned W = 12
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         nrst,
    // Control
    input  wire logic         start,
    input  wire logic [W-1:0] len,
    input  wire logic         tick,
    // Status
    output logic              busy_q,
    output logic              done_q
);
    if (W < 2) begin : g_chk
        $error("ftp_timer: W must be at least 2");
    end

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         busy_d;
    logic         done_d;

    // The length is taken only at start, so a switch change made while
    // a delay runs affects the next delay and not this one.
    always_comb begin
        cnt_d  = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (start) begin
            cnt_d  = len;
            busy_d = (len != '0);
            done_d = (len == '0);
        end else if (busy_q && tick) begin
            cnt_d = cnt_q - 1'b1;
            if (cnt_q == {{(W-1){1'b0}}, 1'b1}) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end
endmodule

// File: verilog/ftp_top.sv
// Furnace timing parameters, switch decode, fan delays and gating.
// Summary of operation
// R1: Prepurge 30 s, inter-trial purge 60 s, postpurge 15 s, never adjustable.
// R2: Two retries, three trials; one hour restart delay after a failed set.
// R3: At most three recycles, four cycles, per heat demand before lockout.
// R4: Flame loss seen within 2 s; faults must persist 2 s first.
// R5: Unexpected flame is judged over a 20 second window.
// R6: After 10 heat cycles with unchanged safety selection, lock it for good.
// R7: Compressor short-cycle delay 5 minutes; cooling fan-on delay 5 seconds.
// R8: Field switch 1 selects cooling fan-off delay: off 0 s, on 60 s.
// R9: Cooling fan-off delay starts at call end; blower stops when elapsed.
// R10: Field switch 2 selects heating fan-on delay: off 30 s, on 60 s.
// R11: Heat fan-on delay starts at trial entry; blower on if trial succeeded.
// R12: Field switches 3,4 select heat fan-off: 120, 180, 90 or 60 s.
// R13: Heat fan-off starts at flame loss after call end; then blower off.
// R14: Safety switches give trial 4/6/6/8 s, activation 1/3/3/5, recognition 3.
// R15: Warm-up 17 s first, 27 s later with switch 1 off; else 30 s.
// R16: Seeing an identical partner on the comm bus enters twinning mode.
// R17: Twinning mode persists until a power cycle.
// R18: Twinned, use shorter fan-on and longer fan-off of both controls.
// R19: After power-up ignore heat 20 s, cooling and fan 10 s.
// R20: All delays count in whole one-second ticks from the system clock.
`timescale 1ns/1ns
`include "ftp_cfg.svh"
module ftp_top #(
    parameter int unsigned TICK_CYC = `FTP_TICK_CYC
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    // Switch banks
    input  wire logic [3:0]        field_setting_switches,
    input  wire logic [1:0]        safety_timing_switches,
    // Thermostat requests
    input  wire logic              heat_call,
    input  wire logic              cool_call,
    input  wire logic              fan_call,
    // Sequencer events and flame
    input  wire logic              trial_enter,
    input  wire logic              trial_ok,
    input  wire logic              first_trial,
    input  wire logic              heat_cycle_done,
    input  wire logic              flame_sense,
    input  wire logic              flame_expected,
    input  wire logic              fault_in,
    // Partner on the comm bus port
    input  wire logic              partner_seen,
    input  wire ftp_pkg::ftp_fan_t partner_fan,
    // Timings and status
    output ftp_pkg::ftp_timing_t   timing_q,
    output logic                   heat_req_q,
    output logic                   cool_req_q,
    output logic                   fan_req_q,
    output logic                   compressor_q,
    output logic                   blower_cool_q,
    output logic                   blower_heat_q,
    output logic                   twin_q,
    output logic                   sel_locked_q,
    output logic [2:0]             supv_q
);
    // ****************************************************************
    // One-second tick and delay timers
    // ****************************************************************
    localparam int unsigned NT = 5;
    localparam int unsigned TW = 12;

    logic                 tick;
    logic [NT-1:0]        t_start;
    logic [NT-1:0]        t_busy;
    logic [NT-1:0]        t_done;
    logic [NT-1:0][TW-1:0] t_len;

    // R20 one second tick
    ftp_tick #(.CYC(TICK_CYC)) u_tick (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .tick_q  (tick)
    );

    // Timers: 0 cool on, 1 cool off, 2 heat on, 3 heat off, 4 short cycle.
    for (genvar i = 0; i < NT; i++) begin : g_tmr
        ftp_timer #(.W(TW)) u_tmr (
            .ref_clk (ref_clk),
            .nrst    (nrst),
            .start   (t_start[i]),
            .len     (t_len[i]),
            .tick    (tick),
            .busy_q  (t_busy[i]),
            .done_q  (t_done[i])
        );
    end

    // ****************************************************************
    // Safety selection lock and twinning
    // ****************************************************************
    logic [1:0] sel_q;
    logic [1:0] sel_d;
    logic [3:0] cyc_q;
    logic [3:0] cyc_d;
    logic       sel_locked_d;
    logic       twin_d;

    // A change of the switches restarts the cycle count; once locked
    // the stored selection no longer follows the switches.
    always_comb begin
        sel_d        = sel_q;
        cyc_d        = cyc_q;
        sel_locked_d = sel_locked_q;
        // R6 selection lock
        if (!sel_locked_q) begin
            if (safety_timing_switches != sel_q) begin
                sel_d = safety_timing_switches;
                cyc_d = 4'h0;
            end else if (heat_cycle_done) begin
                cyc_d = cyc_q + 4'h1;
                if (cyc_d == `FTP_LOCK_CYCLES) begin
                    sel_locked_d = 1'b1;
                end
            end
        end
        // R16 R17 sticky twinning
        twin_d = twin_q | partner_seen;
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sel_q        <= 2'h0;
            cyc_q        <= 4'h0;
            sel_locked_q <= 1'b0;
            twin_q       <= 1'b0;
        end else begin
            sel_q        <= sel_d;
            cyc_q        <= cyc_d;
            sel_locked_q <= sel_locked_d;
            twin_q       <= twin_d;
        end
    end

    // ****************************************************************
    // Timing decode
    // ****************************************************************
    ftp_pkg::ftp_fan_t    own_fan;
    ftp_pkg::ftp_timing_t timing_d;

    always_comb begin
        // R8 cooling fan-off decode
        own_fan.cool_off = field_setting_switches[`FTP_FS_COOL_OFF] ?
                           `FTP_COOL_OFF_ON : `FTP_COOL_OFF_OFF;
        // R10 heating fan-on decode
        own_fan.heat_on  = field_setting_switches[`FTP_FS_HEAT_ON] ?
                           `FTP_HEAT_ON_ON : `FTP_HEAT_ON_OFF;
        // R12 heating fan-off decode
        unique case ({field_setting_switches[`FTP_FS_HOFF_A],
                      field_setting_switches[`FTP_FS_HOFF_B]})
            2'b00: own_fan.heat_off = `FTP_HOFF_00;
            2'b01: own_fan.heat_off = `FTP_HOFF_01;
            2'b10: own_fan.heat_off = `FTP_HOFF_10;
            2'b11: own_fan.heat_off = `FTP_HOFF_11;
        endcase
        // R7 fixed cooling fan-on
        own_fan.cool_on = `FTP_COOL_ON_S;
        timing_d.fan    = own_fan;
        // R18 shorter fan-on and longer fan-off when twinned
        if (twin_q) begin
            if (partner_fan.heat_on < own_fan.heat_on) begin
                timing_d.fan.heat_on = partner_fan.heat_on;
            end
            if (partner_fan.cool_on < own_fan.cool_on) begin
                timing_d.fan.cool_on = partner_fan.cool_on;
            end
            if (partner_fan.heat_off > own_fan.heat_off) begin
                timing_d.fan.heat_off = partner_fan.heat_off;
            end
            if (partner_fan.cool_off > own_fan.cool_off) begin
                timing_d.fan.cool_off = partner_fan.cool_off;
            end
        end
        // R1 fixed purges
        timing_d.prepurge    = `FTP_PREPURGE_S;
        timing_d.interpurge  = `FTP_INTERPURGE_S;
        timing_d.postpurge   = `FTP_POSTPURGE_S;
        // R2 retries and restart delay
        timing_d.retries     = `FTP_RETRIES;
        timing_d.restart     = `FTP_RESTART_S;
        // R3 recycles
        timing_d.recycles    = `FTP_RECYCLES;
        // R7 short cycle delay
        timing_d.short_cycle = `FTP_SHORT_CYC_S;
        // R14 trial from the stored selection, bit 1 is switch 1
        timing_d.recognition = `FTP_RECOG_S;
        timing_d.trial       = {10'h000, sel_q[1] & sel_q[0],
                                sel_q[1] ^ sel_q[0]} * 12'h002 + 12'h004;
        timing_d.activation  = timing_d.trial - `FTP_RECOG_S;
        // R15 igniter warm-up
        if (sel_q[1]) begin
            timing_d.warmup = `FTP_WARM_LONG;
        end else begin
            timing_d.warmup = first_trial ? `FTP_WARM_FIRST : `FTP_WARM_NEXT;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            timing_q <= '0;
        end else begin
            timing_q <= timing_d;
        end
    end

    // ****************************************************************
    // Power-up gating, cooling and blower control
    // ****************************************************************
    logic [4:0] up_q;
    logic [4:0] up_d;
    logic       flame_prev_q;
    logic       heat_req_d;
    logic       cool_req_d;
    logic       fan_req_d;
    logic       compressor_d;
    logic       blower_cool_d;
    logic       blower_heat_d;

    // Timer lengths follow the registered timings.
    assign t_len[0] = timing_q.fan.cool_on;
    assign t_len[1] = timing_q.fan.cool_off;
    assign t_len[2] = timing_q.fan.heat_on;
    assign t_len[3] = timing_q.fan.heat_off;
    assign t_len[4] = timing_q.short_cycle;

    always_comb begin
        // R19 saturating uptime in ticks
        up_d = up_q;
        if (tick && up_q < `FTP_HEAT_GATE_S) begin
            up_d = up_q + 5'h01;
        end
        heat_req_d = heat_call & (up_q >= `FTP_HEAT_GATE_S);
        cool_req_d = cool_call & (up_q >= `FTP_COOL_GATE_S);
        fan_req_d  = fan_call & (up_q >= `FTP_COOL_GATE_S);
        // R7 fan-on at call start, short cycle at call end
        t_start[0] = cool_req_d & ~cool_req_q;
        t_start[4] = ~cool_req_d & cool_req_q;
        // R9 cooling fan-off starts at call end
        t_start[1] = ~cool_req_d & cool_req_q;
        // R11 heating fan-on starts at trial entry
        t_start[2] = trial_enter;
        // R13 heating fan-off at flame loss after the call ended
        t_start[3] = flame_prev_q & ~flame_sense & ~heat_call;
        // R7 compressor held off while the short cycle delay runs
        compressor_d = cool_req_d & ~t_busy[4] & ~t_start[4];
        blower_cool_d = blower_cool_q;
        if (t_done[0] && cool_req_q) begin
            blower_cool_d = 1'b1;
        end else if (t_done[1]) begin
            blower_cool_d = 1'b0;
        end
        blower_heat_d = blower_heat_q;
        if (t_done[2] && trial_ok) begin
            blower_heat_d = 1'b1;
        end else if (t_done[3]) begin
            blower_heat_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            up_q          <= 5'h00;
            flame_prev_q  <= 1'b0;
            heat_req_q    <= 1'b0;
            cool_req_q    <= 1'b0;
            fan_req_q     <= 1'b0;
            compressor_q  <= 1'b0;
            blower_cool_q <= 1'b0;
            blower_heat_q <= 1'b0;
        end else begin
            up_q          <= up_d;
            flame_prev_q  <= flame_sense;
            heat_req_q    <= heat_req_d;
            cool_req_q    <= cool_req_d;
            fan_req_q     <= fan_req_d;
            compressor_q  <= compressor_d;
            blower_cool_q <= blower_cool_d;
            blower_heat_q <= blower_heat_d;
        end
    end

    // ****************************************************************
    // Supervision: flame failure, fault debounce, false flame
    // ****************************************************************
    // A count of N ticks spans more than N-1 seconds, so a least time
    // uses seconds plus one and a longest time seconds minus one.
    localparam logic [5:0] SV_LIM [3] = '{
        6'(`FTP_FLAME_FAIL_S - 12'h001),
        6'(`FTP_DEBOUNCE_S + 12'h001),
        6'(`FTP_FALSE_FLAME_S + 12'h001)};

    logic [2:0] sv_cond;

    assign sv_cond[`FTP_SV_FLAME_FAIL] = flame_expected & ~flame_sense;
    assign sv_cond[`FTP_SV_FAULT]      = fault_in;
    assign sv_cond[`FTP_SV_FALSE]      = ~flame_expected & flame_sense;

    // R4 R5 persistence counters
    for (genvar c = 0; c < 3; c++) begin : g_sv
        logic [5:0] cnt_q;
        logic [5:0] cnt_d;
        logic       flag_d;

        always_comb begin
            cnt_d = 6'h00;
            if (sv_cond[c]) begin
                cnt_d = cnt_q;
                if (tick && cnt_q < SV_LIM[c]) begin
                    cnt_d = cnt_q + 6'h01;
                end
            end
            flag_d = sv_cond[c] & (cnt_d >= SV_LIM[c]);
        end

        always_ff @(posedge ref_clk) begin
            if (!nrst) begin
                cnt_q     <= 6'h00;
                supv_q[c] <= 1'b0;
            end else begin
                cnt_q     <= cnt_d;
                supv_q[c] <= flag_d;
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    chk_purge_fixed: assert property ($past(nrst) |-> // R1
        timing_q.prepurge == 12'h01E && timing_q.interpurge == 12'h03C &&
        timing_q.postpurge == 12'h00F)
        else $error("purge timings changed");
    chk_retry_fixed: assert property ($past(nrst) |-> // R2
        timing_q.retries == 2'h2 && timing_q.restart == 12'hE10)
        else $error("retry or restart timing wrong");
    chk_recycle_cnt: assert property ($past(nrst) |-> // R3
        timing_q.recycles == 2'h3)
        else $error("recycle count wrong");
    chk_fault_debounce: assert property ($rose(supv_q[1]) |-> // R4
        $past(fault_in) && $past(g_sv[1].cnt_q) >= 6'h02)
        else $error("fault flagged before debounce");
    chk_false_flame: assert property (supv_q[2] |-> // R5
        $past(flame_sense) && !$past(flame_expected))
        else $error("false flame without unexpected flame");
    chk_lock_freeze: assert property (sel_locked_q |=> // R6
        sel_locked_q && $stable(sel_q))
        else $error("locked selection changed");
    chk_cool_off_dec: assert property (!twin_q && // R8
        field_setting_switches[0] |=> timing_q.fan.cool_off == 12'h03C)
        else $error("cool fan-off decode wrong");
    chk_heat_fan_on: assert property ($rose(blower_heat_q) |-> // R11
        $past(t_done[2]) && $past(trial_ok))
        else $error("heat blower on without delay and trial");
    chk_twin_sticky: assert property (twin_q |=> twin_q) // R17
        else $error("twinning mode dropped");
    chk_twin_merge: assert property (twin_q |=> // R18
        timing_q.fan.heat_on <= $past(partner_fan.heat_on) &&
        timing_q.fan.heat_off >= $past(partner_fan.heat_off))
        else $error("twinned fan delays not merged");
    chk_pwr_gate: assert property (heat_req_q |-> // R19
        up_q >= 5'h14)
        else $error("heat request passed too early");
endmodule

// File: tb/ftp_partner.sv
// Model of a twinned partner control on the comm bus port.
`timescale 1ns/1ns
module ftp_partner (
    // Clock
    input  wire logic              ref_clk,
    // Presence and own settings
    input  wire logic              present,
    input  wire ftp_pkg::ftp_fan_t fan_set,
    // Comm bus side
    output logic                   partner_seen,
    output ftp_pkg::ftp_fan_t      partner_fan
);
    // Starts absent so the block sees no partner at power-up.
    initial {partner_seen, partner_fan} = '0;
    // announce presence
    // An absent partner sends no settings, so garbage stands there.
    always @(posedge ref_clk) begin
        partner_seen <= present;
        partner_fan  <= present ? fan_set : ~partner_fan;
    end
endmodule

// File: tb/ftp_top_tb.sv
// Self-checking bench of the furnace timing block.
`timescale 1ns/1ns
module ftp_top_tb;
    localparam int unsigned TK = 4;
    logic ref_clk, nrst, heat, cool, fan, ten, tok, ft, hcd;
    logic fls, fle, flt, pres, pseen, hq, cq, fq, comp, bc, bh, twin, lck;
    logic [3:0] fs;
    logic [1:0] ss;
    logic [2:0] sv;
    ftp_pkg::ftp_fan_t    pfan, pset;
    ftp_pkg::ftp_timing_t t;
    int n_errors = 0;
    int checked = 0;
    logic [11:0] hoff [4] = '{12'h078, 12'h0B4, 12'h05A, 12'h03C};
    logic [11:0] tri4 [4] = '{12'h004, 12'h006, 12'h006, 12'h008};
    // ****************************************************************
    // Block, partner and clock
    // ****************************************************************
    ftp_top #(.TICK_CYC(TK)) u_ftp_top (.ref_clk(ref_clk), .nrst(nrst),
        .field_setting_switches(fs), .safety_timing_switches(ss),
        .heat_call(heat), .cool_call(cool), .fan_call(fan),
        .trial_enter(ten), .trial_ok(tok), .first_trial(ft),
        .heat_cycle_done(hcd), .flame_sense(fls), .flame_expected(fle),
        .fault_in(flt), .partner_seen(pseen), .partner_fan(pfan),
        .timing_q(t), .heat_req_q(hq), .cool_req_q(cq), .fan_req_q(fq),
        .compressor_q(comp), .blower_cool_q(bc), .blower_heat_q(bh),
        .twin_q(twin), .sel_locked_q(lck), .supv_q(sv));
    ftp_partner u_ftp_partner (.ref_clk(ref_clk), .present(pres),
        .fan_set(pset), .partner_seen(pseen), .partner_fan(pfan));
    // A 50 ns period gives the 20 MHz system clock.
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    // Inputs only move at the falling edge, away from sampling.
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic chk(input string nm, input logic [11:0] e,
                       input logic [11:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %0d got %0d", nm, e, g);
        end
    endtask
    task automatic pulses(input int n);
        repeat (n) begin
            hcd = 1'b1;
            cyc(1);
            hcd = 1'b0;
            cyc(1);
        end
    endtask
    task automatic give_verdict;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Held requests pass only after their gate time.
    task automatic t_gate;
        cyc(8 * TK);
        chk("fan8", 12'h000, 12'(fq));
        cyc(7 * TK);
        chk("fan15", 12'h001, 12'(fq));
        chk("heat15", 12'h000, 12'(hq));
        cyc(10 * TK);
        chk("heat25", 12'h001, 12'(hq));
        {heat, fan} = 2'b00;
        $display("t_gate done");
    endtask
    task automatic t_fixed;
        chk("pre", 12'h01E, t.prepurge);
        chk("inter", 12'h03C, t.interpurge);
        chk("post", 12'h00F, t.postpurge);
        chk("restart", 12'hE10, t.restart);
        chk("retry", 12'h002, 12'(t.retries));
        chk("recyc", 12'h003, 12'(t.recycles));
        chk("short", 12'h12C, t.short_cycle);
        chk("coolon", 12'h005, t.fan.cool_on);
        $display("t_fixed done");
    endtask
    // Every field switch combination decodes.
    task automatic t_field;
        for (int i = 0; i < 16; i++) begin
            fs = 4'(i);
            cyc(3);
            chk("cooloff", fs[0] ? 12'h03C : 12'h000, t.fan.cool_off);
            chk("heaton", fs[1] ? 12'h03C : 12'h01E, t.fan.heat_on);
            chk("heatoff", hoff[{fs[2], fs[3]}], t.fan.heat_off);
        end
        fs = 4'h0;
        $display("t_field done");
    endtask
    task automatic t_safety;
        for (int i = 0; i < 8; i++) begin
            {ss, ft} = 3'(i);
            cyc(3);
            chk("trial", tri4[ss], t.trial);
            chk("act", tri4[ss] - 12'h003, t.activation);
            chk("recog", 12'h003, t.recognition);
            chk("warm", ss[1] ? 12'h01E : (ft ? 12'h011 : 12'h01B),
                t.warmup);
        end
        {ss, ft} = 3'b000;
        $display("t_safety done");
    endtask
    // Cooling with zero off delay, then a restart inside short-cycle.
    task automatic t_cool;
        cool = 1'b1;
        cyc(3);
        chk("comp", 12'h001, 12'(comp));
        chk("cq", 12'h001, 12'(cq));
        cyc(3 * TK);
        chk("bc3", 12'h000, 12'(bc));
        cyc(3 * TK);
        chk("bc6", 12'h001, 12'(bc));
        cool = 1'b0;
        cyc(3);
        chk("bcoff", 12'h000, 12'(bc));
        cool = 1'b1;
        cyc(2 * TK);
        chk("comp_sc", 12'h000, 12'(comp));
        cool = 1'b0;
        $display("t_cool done");
    endtask
    task automatic t_heat;
        {fs, ten, tok, fls, fle} = 8'hCF;
        cyc(1);
        ten = 1'b0;
        cyc(28 * TK);
        chk("bh0", 12'h000, 12'(bh));
        cyc(4 * TK);
        chk("bh1", 12'h001, 12'(bh));
        {fls, fle} = 2'b00;
        cyc(58 * TK);
        chk("bh2", 12'h001, 12'(bh));
        cyc(3 * TK);
        chk("bh3", 12'h000, 12'(bh));
        $display("t_heat done");
    endtask
    task automatic t_supv;
        flt = 1'b1;
        cyc(TK);
        chk("flt1", 12'h000, 12'(sv[1]));
        cyc(4 * TK);
        chk("flt5", 12'h001, 12'(sv[1]));
        {flt, fle} = 2'b01;
        cyc(2 * TK + 2);
        chk("ffail", 12'h001, 12'(sv[0]));
        {fle, fls} = 2'b01;
        cyc(15 * TK);
        chk("ff15", 12'h000, 12'(sv[2]));
        cyc(8 * TK);
        chk("ff23", 12'h001, 12'(sv[2]));
        fls = 1'b0;
        $display("t_supv done");
    endtask
    // Partner has shorter on and longer off delays.
    task automatic t_twin;
        pset = {12'h003, 12'h05A, 12'h014, 12'h0F0};
        pres = 1'b1;
        cyc(4);
        chk("twin", 12'h001, 12'(twin));
        chk("con", 12'h003, t.fan.cool_on);
        chk("coff", 12'h05A, t.fan.cool_off);
        chk("hon", 12'h014, t.fan.heat_on);
        chk("hoff", 12'h0F0, t.fan.heat_off);
        pres = 1'b0;
        cyc(4);
        chk("sticky", 12'h001, 12'(twin));
        $display("t_twin done");
    endtask
    // A switch change after nine cycles restarts the count.
    task automatic t_lock;
        ss = 2'b01;
        cyc(3);
        pulses(9);
        ss = 2'b10;
        cyc(3);
        pulses(1);
        chk("nolock", 12'h000, 12'(lck));
        pulses(9);
        chk("lock", 12'h001, 12'(lck));
        ss = 2'b11;
        cyc(3);
        chk("held", 12'h006, t.trial);
        $display("t_lock done");
    endtask
    // ****************************************************************
    // Sequence and watchdog
    // ****************************************************************
    initial begin
        {nrst, cool, ten, tok, ft, hcd, fls, fle, flt, pres} = '0;
        {fs, ss, pset} = '0;
        {heat, fan} = 2'b11;
        cyc(5);
        nrst = 1'b1;
        t_gate;
        t_fixed;
        t_field;
        t_safety;
        t_cool;
        t_heat;
        t_supv;
        t_twin;
        t_lock;
        give_verdict;
    end
    // About 800 cycles are needed; allow five times.
    initial begin
        repeat (4000) @(posedge ref_clk);
        n_errors++;
        give_verdict;
    end
endmodule
